// ### ssr_checker.sv
// checker: port-level properties of the status bank
`timescale 1ns/1ps
module ssr_checker
    import ssr_pkg::*;
(
    // clock, reset and inputs
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic normal_mode_i,
    input wire logic [7:0] irq_supply_mask_i,
    input wire logic irq_charger_mask_i,
    input wire logic [7:0] seq_supply_mask_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    // outputs watched
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_hit_o,
    input wire logic status_valid_o,
    input wire logic [7:0] supply_health_bits_o,
    input wire logic [7:0] charger_state_reg_o,
    input wire logic [7:0] irq_supply_evt_o,
    input wire logic irq_charger_evt_o,
    input wire logic supply_health_bits_fault_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    valid_after_mode_a: assert property ($rose(normal_mode_i) |->
        ##[3:5] status_valid_o) else $error("valid late");
    idle_quiet_a: assert property (!$past(status_valid_o) |->
        !supply_health_bits_fault_o && !irq_charger_evt_o && irq_supply_evt_o == 8'h00)
        else $error("evt idle");
    supply_evt_a: assert property (status_valid_o && $past(status_valid_o) |->
        irq_supply_evt_o == (($past(supply_health_bits_o) ^
        supply_health_bits_o) & ~$past(irq_supply_mask_i))) else $error("sevt");
    supply_health_bits_evt_a: assert property (status_valid_o && $past(status_valid_o) |->
        supply_health_bits_fault_o == |(($past(supply_health_bits_o) ^
        supply_health_bits_o) & ~$past(seq_supply_mask_i))) else $error("pg");
    charger_evt_a: assert property (status_valid_o && $past(status_valid_o) |->
        irq_charger_evt_o == (!$past(irq_charger_mask_i) && |(SSR_CHG_IRQ_BITS &
        ($past(charger_state_reg_o) ^ charger_state_reg_o)))) else $error("cevt");
    read_data_a: assert property ($past(reg_rd_i) |-> reg_rdata_o ==
        ($past(reg_addr_i) == SSR_ADDR_SUPPLY ? $past(supply_health_bits_o) :
        $past(reg_addr_i) == SSR_ADDR_CHARGER ? $past(charger_state_reg_o) :
        8'h00)) else $error("rdata");
    rdata_hold_a: assert property (!$past(reg_rd_i) |->
        $stable(reg_rdata_o)) else $error("rdata moved");
    hit_pulse_a: assert property (reg_hit_o == $past((reg_rd_i || reg_wr_i) &&
        (reg_addr_i == SSR_ADDR_SUPPLY || reg_addr_i == SSR_ADDR_CHARGER)))
        else $error("hit");
endmodule
bind ssr_status_regs ssr_checker u_chk(.clk_i(clk_i), .srst_i(srst_i),
    .normal_mode_i(normal_mode_i), .irq_supply_mask_i(irq_supply_mask_i),
    .irq_charger_mask_i(irq_charger_mask_i), .reg_rd_i(reg_rd_i),
    .seq_supply_mask_i(seq_supply_mask_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .status_valid_o(status_valid_o), .supply_health_bits_fault_o(supply_health_bits_fault_o),
    .supply_health_bits_o(supply_health_bits_o),
    .charger_state_reg_o(charger_state_reg_o),
    .irq_supply_evt_o(irq_supply_evt_o), .irq_charger_evt_o(irq_charger_evt_o));

// ### ssr_host_model.sv
// host model: single-cycle register reads and writes
`timescale 1ns/1ps
module ssr_host_model
(
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic rd_o,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial {rd_o, wr_o, addr_o, wdata_o} = 18'h0;
    // released address goes to its inverse so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] ad,
        output logic [7:0] d);
        @(posedge clk_i);
        rd_o <= !wr;
        wr_o <= wr;
        addr_o <= ad;
        wdata_o <= ~wdata_o;
        @(posedge clk_i);
        rd_o <= 1'b0;
        wr_o <= 1'b0;
        addr_o <= ~ad;
        #1 d = rdata_i;
    endtask
endmodule

// ### ssr_pkg.sv
// package: register map and field layout of the system status bank
package ssr_pkg;
    // register addresses
    localparam logic [7:0] SSR_ADDR_SUPPLY = 8'h02;
    localparam logic [7:0] SSR_ADDR_CHARGER = 8'h0A;
    // supply health field positions
    localparam int SSR_BUCK_ONE_BIT = 7;
    localparam int SSR_BUCK_TWO_BIT = 6;
    localparam int SSR_BUCK_THREE_BIT = 5;
    localparam int SSR_LIN_FIVE_BIT = 0;
    // charger field positions
    localparam int SSR_BATT_DISCH_BIT = 7;
    localparam int SSR_INPUT_SEL_BIT = 6;
    localparam int SSR_THERM_PATH_BIT = 5;
    localparam int SSR_WALL_BIT = 4;
    localparam int SSR_USB_BIT = 3;
    localparam int SSR_STATE_HI_BIT = 2;
    localparam int SSR_STATE_LO_BIT = 1;
    localparam int SSR_OVP_BIT = 0;
    // charge state encodings
    localparam logic [1:0] SSR_CHG_OFF = 2'h0;
    localparam logic [1:0] SSR_CHG_DONE = 2'h1;
    localparam logic [1:0] SSR_CHG_FAST = 2'h2;
    localparam logic [1:0] SSR_CHG_PRE = 2'h3;
    // values after reset
    localparam logic [7:0] SSR_RESET_BYTE = 8'h00;
    localparam logic [7:0] SSR_RESET_MASK = 8'hFF;
    // charger bits that may raise an interrupt: discharge bit excluded
    localparam logic [7:0] SSR_CHG_IRQ_BITS = 8'h7F;
    localparam int SSR_SYNC_STAGES = 2;
endpackage

// ### ssr_status_regs.sv
// system status register bank: supply health and charger state
`timescale 1ns/1ps
// How it works
// - valid flag rises only after power-up completes and normal mode begins
// - registers load live status at power-down exit, not a constant
// - address 02 read-only; bits 7..5 bucks, bits 4..0 linear regulators
// - address 0A read-only: discharge, input select, limit, presence, overvoltage
// - charge state bits 2..1: off, done, fast charge, precharge
// - battery discharge bit never raises an interrupt change event
// - internal thermal fault status kept and offered to interrupt logic
// - unmasked status change flagged to interrupt controller for low interrupt
// - unmasked supply health change raises power-good fault to sequencer
module ssr_status_regs
    import ssr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // power state
    input wire logic normal_mode_i,
    // raw supply faults, 1 = fault
    input wire logic buck_converter_one_i,
    input wire logic buck_converter_two_i,
    input wire logic buck_converter_three_i,
    input wire logic [4:0] linear_reg_fault_i,
    // raw charger inputs
    input wire logic battery_discharging_i,
    input wire logic selected_input_source_i,
    input wire logic thermal_or_pathlimit_active_i,
    input wire logic wall_adapter_present_i,
    input wire logic usb_supply_present_i,
    input wire logic charge_state_hi_i,
    input wire logic charge_state_lo_i,
    input wire logic input_overvoltage_i,
    input wire logic thermal_fault_i,
    // masks from the interrupt and sequencer mask registers
    input wire logic [7:0] irq_supply_mask_i,
    input wire logic irq_charger_mask_i,
    input wire logic irq_thermal_mask_i,
    input wire logic [7:0] seq_supply_mask_i,
    // register access
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_hit_o,
    // status outputs
    output logic status_valid_o,
    output logic [7:0] supply_health_bits_o,
    output logic [7:0] charger_state_reg_o,
    output logic thermal_fault_o,
    // events
    output logic [7:0] irq_supply_evt_o,
    output logic irq_charger_evt_o,
    output logic irq_thermal_evt_o,
    output logic supply_health_bits_fault_o
);
    // ----------------------------------------------------------------
    // input synchronisation
    // ----------------------------------------------------------------
    logic [17:0] raw_in;
    logic [17:0] syn_in;
    assign raw_in = {thermal_fault_i, normal_mode_i,
        battery_discharging_i, selected_input_source_i,
        thermal_or_pathlimit_active_i, wall_adapter_present_i,
        usb_supply_present_i, charge_state_hi_i, charge_state_lo_i,
        input_overvoltage_i,
        buck_converter_one_i, buck_converter_two_i,
        buck_converter_three_i, linear_reg_fault_i};

    ssr_sync #(.WIDTH(18)) u_sync (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .async_i(raw_in),
        .sync_o(syn_in)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // held copy against live copy, silent outside normal operation
    function automatic logic [7:0] changed_bits(
        input logic [7:0] live,
        input logic [7:0] held,
        input logic enable
    );
        changed_bits = enable ? (live ^ held) : 8'h00;
    endfunction

    // exact match of the access address against one register offset
    function automatic logic addr_is(
        input logic [7:0] addr,
        input logic [7:0] target
    );
        addr_is = (addr == target);
    endfunction

    // ----------------------------------------------------------------
    // live status words
    // ----------------------------------------------------------------
    logic [7:0] live_supply;
    logic [7:0] live_charger;
    logic live_thermal;
    logic live_normal;
    assign live_supply = syn_in[7:0];
    assign live_charger = syn_in[15:8];
    assign live_normal = syn_in[16];
    assign live_thermal = syn_in[17];

    // ----------------------------------------------------------------
    // power-up tracking
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SSR_PWR_DOWN = 3'b001,
        SSR_PWR_LOAD = 3'b010,
        SSR_PWR_RUN = 3'b100
    } ssr_pwr_e;
    ssr_pwr_e state;
    ssr_pwr_e next_state;

    always_comb
    begin
        next_state = state;
        case (state)
            SSR_PWR_DOWN: if (live_normal) next_state = SSR_PWR_LOAD;
            SSR_PWR_LOAD: next_state = SSR_PWR_RUN;
            SSR_PWR_RUN: if (!live_normal) next_state = SSR_PWR_DOWN;
            default: next_state = SSR_PWR_DOWN;
        endcase
    end

    // ----------------------------------------------------------------
    // status registers
    // ----------------------------------------------------------------
    logic running;
    logic [7:0] supply_chg;
    logic [7:0] charger_chg;
    logic thermal_chg;
    assign running = (state == SSR_PWR_RUN);
    // change detect only while running so the first load raises nothing
    assign supply_chg = changed_bits(live_supply, supply_health_bits_o,
        running);
    assign charger_chg = changed_bits(live_charger, charger_state_reg_o,
        running) & SSR_CHG_IRQ_BITS;
    assign thermal_chg = running & (live_thermal ^ thermal_fault_o);

    // writes are ignored: reg_wdata_i steers nothing and reg_wr_i only sets reg_hit_o
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            state <= SSR_PWR_DOWN;
            status_valid_o <= 1'b0;
            supply_health_bits_o <= SSR_RESET_BYTE;
            charger_state_reg_o <= SSR_RESET_BYTE;
            thermal_fault_o <= 1'b0;
        end
        else
        begin
            state <= next_state;
            status_valid_o <= (next_state == SSR_PWR_RUN);
            if (state != SSR_PWR_DOWN)
            begin
                supply_health_bits_o <= live_supply;
                charger_state_reg_o <= live_charger;
                thermal_fault_o <= live_thermal;
            end
        end
    end

    // ----------------------------------------------------------------
    // events toward interrupt controller and sequencer
    // ----------------------------------------------------------------
    // event words, registered below so every output leaves a flip-flop
    logic [7:0] next_supply_evt;
    logic next_charger_evt;
    logic next_thermal_evt;
    logic next_supply_health_bits_fault;
    assign next_supply_evt = supply_chg & ~irq_supply_mask_i;
    assign next_charger_evt = (|charger_chg) & ~irq_charger_mask_i;
    assign next_thermal_evt = thermal_chg & ~irq_thermal_mask_i;
    assign next_supply_health_bits_fault = |(supply_chg & ~seq_supply_mask_i);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            irq_supply_evt_o <= SSR_RESET_BYTE;
            irq_charger_evt_o <= 1'b0;
            irq_thermal_evt_o <= 1'b0;
            supply_health_bits_fault_o <= 1'b0;
        end
        else
        begin
            irq_supply_evt_o <= next_supply_evt;
            irq_charger_evt_o <= next_charger_evt;
            irq_thermal_evt_o <= next_thermal_evt;
            supply_health_bits_fault_o <= next_supply_health_bits_fault;
        end
    end

    // ----------------------------------------------------------------
    // register read port
    // ----------------------------------------------------------------
    logic hit_supply;
    logic hit_charger;
    logic [7:0] next_rdata;
    assign hit_supply = addr_is(reg_addr_i, SSR_ADDR_SUPPLY);
    assign hit_charger = addr_is(reg_addr_i, SSR_ADDR_CHARGER);
    assign next_rdata = hit_supply ? supply_health_bits_o
        : hit_charger ? charger_state_reg_o : SSR_RESET_BYTE;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            reg_rdata_o <= SSR_RESET_BYTE;
            reg_hit_o <= 1'b0;
        end
        else
        begin
            if (reg_rd_i)
            begin
                reg_rdata_o <= next_rdata;
            end
            reg_hit_o <= (reg_rd_i | reg_wr_i) & (hit_supply | hit_charger);
        end
    end
endmodule

// ### ssr_sync.sv
// two-flop synchroniser for a vector of status levels
`timescale 1ns/1ps
module ssr_sync
    import ssr_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // levels
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] stage_one;

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            stage_one <= '0;
            sync_o <= '0;
        end
        else
        begin
            stage_one <= async_i;
            sync_o <= stage_one;
        end
    end
endmodule

// ### system_status_registers_tb.sv
// testbench for the system status register bank
`timescale 1ns/1ps
module system_status_registers_tb
    import ssr_pkg::*;
();
    logic clk_i, srst_i, nm, icm, itm;
    logic [16:0] st;
    logic [7:0] im, sm, got, e;
    wire logic rd, wr, hit, vld, tf, icev, itev, pgf;
    wire logic [7:0] a, wd, rdata, sup, chg, isev;
    int n_errors, check_count, seed, r, n_ce, n_pg, n_se, n_te;
    ssr_status_regs u_dut(.clk_i(clk_i), .srst_i(srst_i), .normal_mode_i(nm),
        .buck_converter_one_i(st[15]), .buck_converter_two_i(st[14]),
        .buck_converter_three_i(st[13]), .linear_reg_fault_i(st[12:8]),
        .battery_discharging_i(st[7]), .selected_input_source_i(st[6]),
        .thermal_or_pathlimit_active_i(st[5]), .wall_adapter_present_i(st[4]),
        .usb_supply_present_i(st[3]), .charge_state_hi_i(st[2]),
        .charge_state_lo_i(st[1]), .input_overvoltage_i(st[0]),
        .thermal_fault_i(st[16]), .irq_supply_mask_i(im),
        .irq_charger_mask_i(icm), .irq_thermal_mask_i(itm),
        .seq_supply_mask_i(sm), .reg_rd_i(rd), .reg_wr_i(wr), .reg_addr_i(a),
        .reg_wdata_i(wd), .reg_rdata_o(rdata), .reg_hit_o(hit),
        .status_valid_o(vld), .supply_health_bits_o(sup),
        .charger_state_reg_o(chg), .thermal_fault_o(tf),
        .irq_supply_evt_o(isev), .irq_charger_evt_o(icev),
        .irq_thermal_evt_o(itev), .supply_health_bits_fault_o(pgf));
    ssr_host_model u_host(.clk_i(clk_i), .rdata_i(rdata), .rd_o(rd),
        .wr_o(wr), .addr_o(a), .wdata_o(wd));
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        n_ce += icev;
        n_pg += pgf;
        n_se += $countones(isev);
        n_te += itev;
    end
    function automatic logic [7:0] f_sup(input logic [16:0] s);
        return s[15:8];
    endfunction
    task chk(input logic [7:0] g, input logic [7:0] x);
        check_count++;
        if (g !== x)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task rdc(input logic [7:0] ad, input logic [7:0] x);
        u_host.xfer(1'b0, ad, got);
        chk(got, x);
    endtask
    task test_done;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // limit is over ten times the expected run length
    initial
    begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        test_done;
    end
    initial
    begin
        {nm, icm, itm, im, sm, st} = 36'h0;
        seed = 32'hFE6F;
        srst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        srst_i <= 1'b0;
        r = $random(seed);
        st <= r[16:0];
        repeat (4) @(posedge clk_i);
        chk({7'h00, vld}, 8'h00);
        nm <= 1'b1;
        repeat (8) @(posedge clk_i);
        rdc(SSR_ADDR_SUPPLY, f_sup(st));
        rdc(SSR_ADDR_CHARGER, st[7:0]);
        for (int i = 0; i < 16; i++)
        begin
            @(posedge clk_i);
            r = $random(seed);
            {itm, icm, sm, im} <= r[17:0];
            r = $random(seed);
            st <= {r[16:3], i[1:0], r[0]};
            repeat (6) @(posedge clk_i);
            rdc(SSR_ADDR_SUPPLY, f_sup(st));
            rdc(SSR_ADDR_CHARGER, st[7:0]);
            chk({7'h00, tf}, {7'h00, st[16]});
            u_host.xfer(1'b1, r[31:24], got);
            u_host.xfer(1'b1, SSR_ADDR_CHARGER, got);
            rdc(SSR_ADDR_CHARGER, st[7:0]);
            u_host.xfer(1'b1, SSR_ADDR_SUPPLY, got);
            rdc(SSR_ADDR_SUPPLY, f_sup(st));
            rdc({r[31:26], 2'h3}, 8'h00);
        end
        @(posedge clk_i);
        {itm, icm, sm, im} <= 18'h0;
        repeat (6) @(posedge clk_i);
        {n_ce, n_pg, n_se, n_te} = 128'h0;
        st <= st ^ 17'h18080;
        repeat (8) @(posedge clk_i);
        chk(n_ce[7:0], 8'h00);
        chk(n_se[7:0], 8'h01);
        chk(n_pg[7:0], 8'h01);
        chk(n_te[7:0], 8'h01);
        e = f_sup(st);
        nm <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk({7'h00, vld}, 8'h00);
        st <= ~st;
        repeat (6) @(posedge clk_i);
        rdc(SSR_ADDR_SUPPLY, e);
        nm <= 1'b1;
        repeat (8) @(posedge clk_i);
        rdc(SSR_ADDR_SUPPLY, f_sup(st));
        test_done;
    end
endmodule
